//--- core/hrd_restraint.sv
// three-phase second and fifth harmonic restraint decision
`timescale 1ns/1ps
`default_nettype none
module hrd_restraint
	import hrd_pkg::*;
#(
	parameter int MW = 16,
	parameter int CW = 22,
	parameter int QUAL50 = hrd_pkg::QUAL_50_CYC,
	parameter int QUAL60 = hrd_pkg::QUAL_60_CYC,
	parameter int DROP50 = hrd_pkg::DROP_50_CYC,
	parameter int DROP60 = hrd_pkg::DROP_60_CYC,
	parameter int INRUSH50 = hrd_pkg::INRUSH_50_CYC,
	parameter int INRUSH60 = hrd_pkg::INRUSH_60_CYC,
	parameter int MSCYC = hrd_pkg::MS_CYC
) (
	input wire logic SYS_CLK,
	input wire logic RST_B,
	input wire logic [MW-1:0] FUND_DIFF_PHASE1,
	input wire logic [MW-1:0] FUND_DIFF_PHASE2,
	input wire logic [MW-1:0] FUND_DIFF_PHASE3,
	input wire logic [MW-1:0] H2_DIFF_PHASE1,
	input wire logic [MW-1:0] H2_DIFF_PHASE2,
	input wire logic [MW-1:0] H2_DIFF_PHASE3,
	input wire logic [MW-1:0] H5_DIFF_PHASE1,
	input wire logic [MW-1:0] H5_DIFF_PHASE2,
	input wire logic [MW-1:0] H5_DIFF_PHASE3,
	input wire logic [MW-1:0] PHASE_CUR_PHASE1,
	input wire logic [MW-1:0] PHASE_CUR_PHASE2,
	input wire logic [MW-1:0] PHASE_CUR_PHASE3,
	input wire logic [MW-1:0] SIDE1_MAG,
	input wire logic [MW-1:0] SIDE2_MAG,
	input wire logic [7:0] ANGLE_DIFF,
	input wire logic [MW-1:0] REF_CUR,
	input wire logic [MW-1:0] MIN_DIFF_CUR,
	input wire logic CFG_LOAD,
	input wire logic [6:0] H2_RATIO_SETTING,
	input wire logic [6:0] H5_RATIO_SETTING,
	input wire logic CROSS_BLOCK_ENABLE,
	input wire logic [15:0] CROSS_BLOCK_TIME_LIMIT,
	input wire logic FREQ_SEL_60,
	output logic H2_DETECT_PHASE1,
	output logic H2_DETECT_PHASE2,
	output logic H2_DETECT_PHASE3,
	output logic H2_RESTRAINT_PHASE1,
	output logic H2_RESTRAINT_PHASE2,
	output logic H2_RESTRAINT_PHASE3,
	output logic H2_RESTRAINT_ANY,
	output logic H5_RESTRAINT_PHASE1,
	output logic H5_RESTRAINT_PHASE2,
	output logic H5_RESTRAINT_PHASE3,
	output logic H5_RESTRAINT_ANY,
	output logic BLOCK_PHASE1,
	output logic BLOCK_PHASE2,
	output logic BLOCK_PHASE3,
	output logic CROSS_BLOCK_ACTIVE,
	output logic INRUSH_COND,
	output logic EXT_FAULT_COND
);
	import hrd_pkg::*;

	if (QUAL50 < 1 || QUAL60 < 1 || DROP50 < 1 || DROP60 < 1)
		$error("hold counts must be at least one cycle");
	if (longint'(QUAL50) >= (longint'(1) << CW) ||
		longint'(QUAL60) >= (longint'(1) << CW) ||
		longint'(DROP50) >= (longint'(1) << CW) ||
		longint'(DROP60) >= (longint'(1) << CW))
		$error("hold counts do not fit the timer width");
	if (INRUSH50 < 1 || INRUSH60 < 1 || MSCYC < 1 || MW < 2 || MW > 24)
		$error("unsupported parameter value");

	logic [MW-1:0] fund [PHASES];
	logic [MW-1:0] h2 [PHASES];
	logic [MW-1:0] h5 [PHASES];
	logic [MW-1:0] cur [PHASES];
	logic [PHASES-1:0] h2_high, h5_high, h2_flag, h5_flag;
	logic [PHASES-1:0] h2_gated, own_blk;
	logic [PHASES-1:0] h2_det_r, h2_rst_r, h5_rst_r, blk_r;
	logic h2_any_r, h5_any_r, xb_out_r, inrush_r, ext_r;
	logic [6:0] h2_set_r, h5_set_r;
	logic [15:0] xlim_r;
	logic xen_r, freq60_r;
	logic [CW-1:0] qual_cnt, drop_cnt;
	logic [31:0] inrush_cnt_r;
	logic [31:0] inrush_tgt;
	logic energised, inrush_ok;
	logic [31:0] ms_pre_r;
	logic [15:0] xms_r;
	logic any_rst;
	hrd_xb_t xb_r, xb_nxt;

	assign fund[0] = FUND_DIFF_PHASE1;
	assign fund[1] = FUND_DIFF_PHASE2;
	assign fund[2] = FUND_DIFF_PHASE3;
	assign h2[0] = H2_DIFF_PHASE1;
	assign h2[1] = H2_DIFF_PHASE2;
	assign h2[2] = H2_DIFF_PHASE3;
	assign h5[0] = H5_DIFF_PHASE1;
	assign h5[1] = H5_DIFF_PHASE2;
	assign h5[2] = H5_DIFF_PHASE3;
	assign cur[0] = PHASE_CUR_PHASE1;
	assign cur[1] = PHASE_CUR_PHASE2;
	assign cur[2] = PHASE_CUR_PHASE3;

	// x as percent of base exceeds pct, without a divider
	function automatic logic pct_above(input logic [MW-1:0] x,
		input logic [MW-1:0] base, input logic [6:0] pct);
		logic [MW+6:0] lhs;
		logic [MW+6:0] rhs;
		lhs = x * PCT_FULL;
		rhs = base * pct;
		return lhs > rhs;
	endfunction

	function automatic logic [6:0] clamp_ratio(input logic [6:0] v);
		if (v < RATIO_MIN)
			return RATIO_MIN;
		if (v > RATIO_MAX)
			return RATIO_MAX;
		return v;
	endfunction

	// settings are loaded on strobe, defaults after reset
	always_ff @(posedge SYS_CLK) begin
		if (!RST_B) begin
			h2_set_r <= H2_RATIO_RST;
			h5_set_r <= H5_RATIO_RST;
			xen_r <= XEN_RST;
			xlim_r <= XLIM_RST_MS;
			freq60_r <= FREQ60_RST;
		end else if (CFG_LOAD) begin
			h2_set_r <= clamp_ratio(H2_RATIO_SETTING);
			h5_set_r <= clamp_ratio(H5_RATIO_SETTING);
			xen_r <= CROSS_BLOCK_ENABLE;
			freq60_r <= FREQ_SEL_60;
			if (CROSS_BLOCK_TIME_LIMIT < XLIM_MIN_MS)
				xlim_r <= XLIM_MIN_MS;
			else if (CROSS_BLOCK_TIME_LIMIT > XLIM_MAX_MS)
				xlim_r <= XLIM_MAX_MS;
			else
				xlim_r <= CROSS_BLOCK_TIME_LIMIT;
		end
	end

	assign qual_cnt = freq60_r ? CW'(QUAL60) : CW'(QUAL50);
	assign drop_cnt = freq60_r ? CW'(DROP60) : CW'(DROP50);
	assign inrush_tgt = freq60_r ? 32'(INRUSH60) : 32'(INRUSH50);

	for (genvar p = 0; p < PHASES; p++) begin : g_phase
		// below minimum differential current nothing is judged
		assign h2_high[p] = (fund[p] >= MIN_DIFF_CUR) &&
			pct_above(h2[p], fund[p], h2_set_r);
		assign h5_high[p] = (fund[p] >= MIN_DIFF_CUR) &&
			pct_above(h5[p], fund[p], h5_set_r);

		hrd_hold_timer #(.CW(CW)) u_h2 (
			.clk(SYS_CLK),
			.rst_b(RST_B),
			.high(h2_high[p]),
			.qual_cnt(qual_cnt),
			.drop_cnt(drop_cnt),
			.flag(h2_flag[p])
		);

		hrd_hold_timer #(.CW(CW)) u_h5 (
			.clk(SYS_CLK),
			.rst_b(RST_B),
			.high(h5_high[p]),
			.qual_cnt(qual_cnt),
			.drop_cnt(drop_cnt),
			.flag(h5_flag[p])
		);
	end

	assign h2_gated = h2_flag & {PHASES{inrush_r || ext_r}};
	assign own_blk = h2_gated | h5_flag;
	assign any_rst = |own_blk;

	always_ff @(posedge SYS_CLK) begin
		if (!RST_B) begin
			h2_det_r <= '0;
			h2_rst_r <= '0;
			h5_rst_r <= '0;
			h2_any_r <= 1'b0;
			h5_any_r <= 1'b0;
		end else begin
			h2_det_r <= h2_flag;
			h2_rst_r <= h2_gated;
			h5_rst_r <= h5_flag;
			h2_any_r <= |h2_gated;
			h5_any_r <= |h5_flag;
		end
	end

	// transformer counts as energised once any phase passes 2%
	always_comb begin
		energised = 1'b0;
		for (int p = 0; p < PHASES; p++)
			energised = energised || pct_above(cur[p], REF_CUR, ENERGISED_PCT);
	end
	assign inrush_ok = energised && (h2_flag == '0);

	always_ff @(posedge SYS_CLK) begin
		if (!RST_B)
			inrush_cnt_r <= '0;
		else if (!inrush_ok || !inrush_r)
			inrush_cnt_r <= '0;
		else if (inrush_cnt_r != inrush_tgt)
			inrush_cnt_r <= inrush_cnt_r + 1'b1;
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_B)
			inrush_r <= 1'b1;
		else if (!energised)
			inrush_r <= 1'b1;
		else if (inrush_ok && inrush_cnt_r == inrush_tgt)
			inrush_r <= 1'b0;
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_B)
			ext_r <= 1'b0;
		else
			ext_r <= pct_above(SIDE1_MAG, REF_CUR, ANGLE_VALID_PCT) &&
				pct_above(SIDE2_MAG, REF_CUR, ANGLE_VALID_PCT) &&
				(ANGLE_DIFF >= EXT_ANGLE_DEG);
	end

	// millisecond base for the cross blocking limit
	always_ff @(posedge SYS_CLK) begin
		if (!RST_B || xb_r != XB_ACTIVE)
			ms_pre_r <= '0;
		else if (ms_pre_r == 32'(MSCYC - 1))
			ms_pre_r <= '0;
		else
			ms_pre_r <= ms_pre_r + 1'b1;
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_B || xb_r != XB_ACTIVE)
			xms_r <= '0;
		else if (ms_pre_r == 32'(MSCYC - 1))
			xms_r <= xms_r + 1'b1;
	end

	always_comb begin
		xb_nxt = xb_r;
		unique case (xb_r)
			XB_IDLE:
				if (any_rst && xen_r)
					xb_nxt = XB_ACTIVE;
			XB_ACTIVE:
				if (!any_rst || !xen_r)
					xb_nxt = XB_IDLE;
				else if (xms_r >= xlim_r)
					xb_nxt = XB_EXPIRED;
			XB_EXPIRED:
				if (!any_rst)
					xb_nxt = XB_IDLE;
			default:
				xb_nxt = XB_IDLE;
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_B)
			xb_r <= XB_IDLE;
		else
			xb_r <= xb_nxt;
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_B) begin
			blk_r <= '0;
			xb_out_r <= 1'b0;
		end else begin
			xb_out_r <= (xb_nxt == XB_ACTIVE);
			if (xb_nxt == XB_ACTIVE)
				blk_r <= '1;
			else
				blk_r <= own_blk;
		end
	end

	assign H2_DETECT_PHASE1 = h2_det_r[0];
	assign H2_DETECT_PHASE2 = h2_det_r[1];
	assign H2_DETECT_PHASE3 = h2_det_r[2];
	assign H2_RESTRAINT_PHASE1 = h2_rst_r[0];
	assign H2_RESTRAINT_PHASE2 = h2_rst_r[1];
	assign H2_RESTRAINT_PHASE3 = h2_rst_r[2];
	assign H2_RESTRAINT_ANY = h2_any_r;
	assign H5_RESTRAINT_PHASE1 = h5_rst_r[0];
	assign H5_RESTRAINT_PHASE2 = h5_rst_r[1];
	assign H5_RESTRAINT_PHASE3 = h5_rst_r[2];
	assign H5_RESTRAINT_ANY = h5_any_r;
	assign BLOCK_PHASE1 = blk_r[0];
	assign BLOCK_PHASE2 = blk_r[1];
	assign BLOCK_PHASE3 = blk_r[2];
	assign CROSS_BLOCK_ACTIVE = xb_out_r;
	assign INRUSH_COND = inrush_r;
	assign EXT_FAULT_COND = ext_r;

	h2_gate_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		$rose(h2_rst_r[0]) |-> $past(inrush_r || ext_r))
		else $error("second restraint without gating condition");
	h2_summary_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		h2_any_r == (|h2_rst_r))
		else $error("second summary differs from phases");
	det_covers_rst_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		(h2_rst_r & ~h2_det_r) == '0)
		else $error("restraint without detection");
	h5_summary_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		h5_any_r == (|h5_rst_r))
		else $error("fifth summary differs from phases");
	ext_angle_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		ext_r |-> $past(ANGLE_DIFF) >= EXT_ANGLE_DEG)
		else $error("external fault below angle threshold");
	ext_valid_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		ext_r |-> $past(SIDE1_MAG) != '0 && $past(SIDE2_MAG) != '0)
		else $error("external fault with zero side current");
	no_cross_off_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		!xen_r |=> !xb_out_r)
		else $error("cross blocking while disabled");
	cross_all_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		xb_out_r |-> blk_r == '1)
		else $error("cross blocking misses a phase");
	cross_limit_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		(xb_r == XB_ACTIVE && xms_r >= xlim_r) |=> !xb_out_r)
		else $error("cross blocking past its limit");
	inrush_hold_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		$fell(inrush_r) |-> $past(inrush_cnt_r) == $past(inrush_tgt))
		else $error("inrush cleared before its delay");
	cfg_default_a: assert property (@(posedge SYS_CLK)
		!RST_B |=> xen_r && h2_set_r == H2_RATIO_RST &&
		h5_set_r == H5_RATIO_RST && xlim_r == XLIM_RST_MS && !freq60_r)
		else $error("configuration defaults not restored");
	ratio_range_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		h2_set_r >= RATIO_MIN && h2_set_r <= RATIO_MAX &&
		h5_set_r >= RATIO_MIN && h5_set_r <= RATIO_MAX)
		else $error("ratio setting out of range");
endmodule
`default_nettype wire

//--- core/hrd_pkg.sv
// constants shared by the harmonic restraint decision block
package hrd_pkg;
	localparam longint CLK_PERIOD_NS = 10;
	localparam longint QUAL_50_NS = 25_000_000;
	localparam longint QUAL_60_NS = 20_830_000;
	localparam longint DROP_50_NS = 15_000_000;
	localparam longint DROP_60_NS = 12_500_000;
	localparam longint INRUSH_50_NS = 5_000_000_000;
	localparam longint INRUSH_60_NS = 4_166_670_000;
	localparam longint MS_NS = 1_000_000;
	localparam int QUAL_50_CYC =
		int'((QUAL_50_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int QUAL_60_CYC =
		int'((QUAL_60_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int DROP_50_CYC =
		int'((DROP_50_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int DROP_60_CYC =
		int'((DROP_60_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int INRUSH_50_CYC =
		int'((INRUSH_50_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int INRUSH_60_CYC =
		int'((INRUSH_60_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int MS_CYC =
		int'((MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [6:0] PCT_FULL = 7'h64;
	localparam logic [6:0] RATIO_MIN = 7'h05;
	localparam logic [6:0] RATIO_MAX = 7'h32;
	localparam logic [6:0] H2_RATIO_RST = 7'h0f;
	localparam logic [6:0] H5_RATIO_RST = 7'h19;
	localparam logic [6:0] ENERGISED_PCT = 7'h02;
	localparam logic [6:0] ANGLE_VALID_PCT = 7'h0a;
	localparam logic [7:0] EXT_ANGLE_DEG = 8'h4b;
	localparam logic [15:0] XLIM_MIN_MS = 16'h0064;
	localparam logic [15:0] XLIM_MAX_MS = 16'hea60;
	localparam logic [15:0] XLIM_RST_MS = 16'h1388;
	localparam logic XEN_RST = 1'b1;
	localparam logic FREQ60_RST = 1'b0;
	localparam int PHASES = 3;
	typedef enum logic [1:0] {XB_IDLE, XB_ACTIVE, XB_EXPIRED} hrd_xb_t;
endpackage

//--- core/hrd_hold_timer.sv
// qualification and drop-off hold of one harmonic flag
`timescale 1ns/1ps
`default_nettype none
module hrd_hold_timer #(
	parameter int CW = 22
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic high,
	input wire logic [CW-1:0] qual_cnt,
	input wire logic [CW-1:0] drop_cnt,
	output logic flag
);
	logic [CW-1:0] qual_r;
	logic [CW-1:0] drop_r;
	logic qualified_r;

	// counts uninterrupted high cycles, restarts on any gap
	always_ff @(posedge clk) begin
		if (!rst_b)
			qual_r <= '0;
		else if (!high)
			qual_r <= '0;
		else if (qual_r != qual_cnt)
			qual_r <= qual_r + 1'b1;
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			qualified_r <= 1'b0;
		else
			qualified_r <= high && (qual_r >= qual_cnt - 1'b1);
	end

	// extension covers drop_cnt cycles including the falling one
	always_ff @(posedge clk) begin
		if (!rst_b)
			drop_r <= '0;
		else if (high)
			drop_r <= '0;
		else if (qualified_r)
			drop_r <= drop_cnt - 1'b1;
		else if (drop_r != '0)
			drop_r <= drop_r - 1'b1;
	end

	assign flag = high || qualified_r || (drop_r != '0);

	qual_needs_high_a: assert property (@(posedge clk) disable iff (!rst_b)
		qualified_r |-> $past(high) &&
		$past(qual_r) >= $past(qual_cnt) - 1'b1)
		else $error("qualified without full high run");
	drop_load_a: assert property (@(posedge clk) disable iff (!rst_b)
		(!high && qualified_r) |=> drop_r == $past(drop_cnt) - 1'b1)
		else $error("drop timer not loaded");
endmodule
`default_nettype wire

//--- verification/hrd_harm_src.sv
// upstream harmonic magnitudes feeding the restraint block
`timescale 1ns/1ps
`default_nettype none
module hrd_harm_src (
	output logic [15:0] fund [3],
	output logic [15:0] h2 [3],
	output logic [15:0] h5 [3]
);
	initial begin
		for (int i = 0; i < 3; i++) begin
			fund[i] = 16'h03e8;
			h2[i] = 16'h0000;
			h5[i] = 16'h0000;
		end
	end
	// only called just after a falling edge
	task automatic put(input int p, input int f, input int a, input int b);
		fund[p] = 16'(f);
		h2[p] = 16'(a);
		h5[p] = 16'(b);
	endtask
endmodule
`default_nettype wire

//--- verification/testbench.sv
// self-checking bench for the harmonic restraint block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import hrd_pkg::*;
	localparam int Q50 = 4;
	localparam int Q60 = 3;
	localparam int D50 = 3;
	localparam int D60 = 2;
	localparam int INR = 50;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [15:0] fd [3];
	logic [15:0] h2v [3];
	logic [15:0] h5v [3];
	logic [15:0] pc [3] = '{16'h0, 16'h0, 16'h0};
	logic [15:0] s1 = 16'h0;
	logic [15:0] s2 = 16'h0;
	logic [7:0] ang = 8'h0;
	logic [15:0] refc = 16'h03e8;
	logic [15:0] minc = 16'h0064;
	logic ld = 1'b0;
	logic [6:0] r2s = 7'h0f;
	logic [6:0] r5s = 7'h19;
	logic xen = 1'b1;
	logic [15:0] xlim = 16'h1388;
	logic f60 = 1'b0;
	logic [2:0] det, h2r, h5r, blk;
	logic h2any, h5any, xact, inr, ext;
	int bad_count = 0;
	int tests_run = 0;
	int seed = 43148;
	int r2m = 15;
	int r5m = 25;
	int mind = 100;
	logic xm = 1'b1;

	always #5 sys_clk = ~sys_clk;

	hrd_harm_src up (.fund(fd), .h2(h2v), .h5(h5v));

	hrd_restraint #(.QUAL50(Q50), .QUAL60(Q60), .DROP50(D50), .DROP60(D60),
		.INRUSH50(INR), .INRUSH60(INR), .MSCYC(10)) dut (
		.SYS_CLK(sys_clk), .RST_B(rst_b),
		.FUND_DIFF_PHASE1(fd[0]), .FUND_DIFF_PHASE2(fd[1]),
		.FUND_DIFF_PHASE3(fd[2]), .H2_DIFF_PHASE1(h2v[0]),
		.H2_DIFF_PHASE2(h2v[1]), .H2_DIFF_PHASE3(h2v[2]),
		.H5_DIFF_PHASE1(h5v[0]), .H5_DIFF_PHASE2(h5v[1]),
		.H5_DIFF_PHASE3(h5v[2]), .PHASE_CUR_PHASE1(pc[0]),
		.PHASE_CUR_PHASE2(pc[1]), .PHASE_CUR_PHASE3(pc[2]),
		.SIDE1_MAG(s1), .SIDE2_MAG(s2), .ANGLE_DIFF(ang), .REF_CUR(refc),
		.MIN_DIFF_CUR(minc), .CFG_LOAD(ld), .H2_RATIO_SETTING(r2s),
		.H5_RATIO_SETTING(r5s), .CROSS_BLOCK_ENABLE(xen),
		.CROSS_BLOCK_TIME_LIMIT(xlim), .FREQ_SEL_60(f60),
		.H2_DETECT_PHASE1(det[0]), .H2_DETECT_PHASE2(det[1]),
		.H2_DETECT_PHASE3(det[2]), .H2_RESTRAINT_PHASE1(h2r[0]),
		.H2_RESTRAINT_PHASE2(h2r[1]), .H2_RESTRAINT_PHASE3(h2r[2]),
		.H2_RESTRAINT_ANY(h2any), .H5_RESTRAINT_PHASE1(h5r[0]),
		.H5_RESTRAINT_PHASE2(h5r[1]), .H5_RESTRAINT_PHASE3(h5r[2]),
		.H5_RESTRAINT_ANY(h5any), .BLOCK_PHASE1(blk[0]),
		.BLOCK_PHASE2(blk[1]), .BLOCK_PHASE3(blk[2]),
		.CROSS_BLOCK_ACTIVE(xact), .INRUSH_COND(inr), .EXT_FAULT_COND(ext));

	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	task automatic chk(input string nm, input logic [3:0] e,
		input logic [3:0] g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic stop_test;
		$display("counts: %0d checks, %0d mismatches", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// load all five settings; model mirrors the clamping
	task automatic cfg(input int a, input int b, input logic en,
		input int lim, input logic s);
		r2s = 7'(a);
		r5s = 7'(b);
		xen = en;
		xlim = 16'(lim);
		f60 = s;
		r2m = a < 5 ? 5 : (a > 50 ? 50 : a);
		r5m = b < 5 ? 5 : (b > 50 ? 50 : b);
		xm = en;
		ld = 1'b1;
		cyc(1);
		ld = 1'b0;
	endtask

	// one-cycle harmonic burst on phase p, checked against the model
	task automatic probe(input int p, input int f, input int a, input int b);
		logic [2:0] e2, e5;
		e2 = '0;
		e5 = '0;
		e2[p] = (f >= mind) && (a * 100 > f * r2m);
		e5[p] = (f >= mind) && (b * 100 > f * r5m);
		up.put(p, f, a, b);
		cyc(1);
		chk("h2 detect", {1'b0, e2}, {1'b0, det});
		chk("h2 restraint", {1'b0, e2}, {1'b0, h2r});
		chk("h2 any", {3'b0, |e2}, {3'b0, h2any});
		chk("h5 restraint", {1'b0, e5}, {1'b0, h5r});
		chk("h5 any", {3'b0, |e5}, {3'b0, h5any});
		chk("own block", {3'b0, e2[p] | e5[p]}, {3'b0, blk[p]});
		chk("cross active", {3'b0, xm & |(e2 | e5)}, {3'b0, xact});
		chk("cross block", {1'b0, (xm && |(e2 | e5)) ? 3'b111 : (e2 | e5)},
			{1'b0, blk});
		up.put(p, f, 0, 0);
		cyc(1);
		chk("short drop", 4'h0, {1'b0, det | h5r});
		chk("cross release", 4'h0, {xact, blk});
		cyc(2);
	endtask

	// hold a high second harmonic n cycles, count extension cycles
	task automatic hold(input int n, input int d);
		int k;
		k = 0;
		up.put(0, 1000, 500, 0);
		cyc(n);
		up.put(0, 1000, 0, 0);
		for (int i = 0; i < 8; i++) begin
			cyc(1);
			if (det[0] === 1'b1) k++;
		end
		chk("drop length", 4'(d), 4'(k));
	endtask

	initial begin
		cyc(20000);
		bad_count++;
		stop_test();
	end

	initial begin
		int f;
		cyc(5);
		rst_b = 1'b1;
		cyc(1);
		chk("inrush after reset", 4'h1, {3'b0, inr});
		for (int p = 0; p < 3; p++) begin
			probe(p, 1000, 150, 250);
			probe(p, 1000, 151, 251);
		end
		probe(1, 99, 90, 90);
		cfg(60, 2, 1'b0, 5000, 1'b0);
		probe(0, 1000, 501, 51);
		probe(0, 1000, 500, 50);
		for (int i = 0; i < 60; i++) begin
			if (i % 10 == 0) begin
				cfg(5 + $unsigned($random(seed)) % 46,
					5 + $unsigned($random(seed)) % 46,
					1'($random(seed)), 5000, 1'b0);
			end
			f = 50 + $unsigned($random(seed)) % 4000;
			probe($unsigned($random(seed)) % 3,
				f, $unsigned($random(seed)) % (f * 6 / 10 + 1),
				$unsigned($random(seed)) % (f * 6 / 10 + 1));
		end
		$display("ratio test done");
		cfg(15, 25, 1'b0, 5000, 1'b0);
		hold(Q50, D50);
		hold(Q50 - 1, 0);
		cfg(15, 25, 1'b0, 5000, 1'b1);
		hold(Q60, D60);
		hold(Q60 - 1, 0);
		cfg(15, 25, 1'b0, 5000, 1'b0);
		$display("timer test done");
		pc[0] = 16'd30;
		cyc(INR / 2);
		chk("inrush held", 4'h1, {3'b0, inr});
		cyc(INR);
		chk("inrush cleared", 4'h0, {3'b0, inr});
		up.put(1, 1000, 500, 0);
		cyc(2);
		chk("ungated detect", 4'h1, {3'b0, det[1]});
		chk("gated off", 4'h0, {3'b0, h2r[1]});
		s1 = 16'd200;
		s2 = 16'd200;
		ang = 8'd75;
		cyc(2);
		chk("ext fault", 4'h1, {3'b0, ext});
		chk("gated on", 4'h1, {3'b0, h2r[1]});
		ang = 8'd74;
		cyc(2);
		chk("ext angle low", 4'h0, {3'b0, ext});
		ang = 8'd90;
		s2 = 16'd100;
		cyc(2);
		chk("ext side low", 4'h0, {3'b0, ext});
		s2 = 16'd101;
		cyc(2);
		chk("ext side ok", 4'h1, {3'b0, ext});
		up.put(1, 1000, 0, 0);
		ang = 8'd0;
		pc[0] = 16'd20;
		cyc(10);
		chk("inrush back", 4'h1, {3'b0, inr});
		$display("gating test done");
		cfg(15, 25, 1'b1, 50, 1'b0);
		up.put(1, 1000, 0, 300);
		cyc(3);
		chk("cross on", 4'h1, {3'b0, xact});
		chk("cross all", 4'h7, {1'b0, blk});
		cyc(900);
		chk("cross kept", 4'h1, {3'b0, xact});
		cyc(200);
		chk("cross ended", 4'h0, {3'b0, xact});
		chk("self block", 4'h2, {1'b0, blk});
		up.put(1, 1000, 0, 0);
		cyc(10);
		cfg(15, 25, 1'b0, 5000, 1'b0);
		up.put(2, 1000, 0, 300);
		cyc(3);
		chk("no cross", 4'h4, {xact, blk});
		up.put(2, 1000, 0, 0);
		cyc(10);
		$display("cross test done");
		stop_test();
	end
endmodule
`default_nettype wire
